// >>> core/dac_latch_consts.vh
// constants for the serial dac input latch
`ifndef DAC_LATCH_CONSTS_VH
`define DAC_LATCH_CONSTS_VH
`define WORD_BITS 16
`define CNT_BITS 5
`define FULL_CNT 5'h10
`define SEG_COUNT 15
`define SEG_TOP_BITS 4
`define ZERO_CODE 16'h0000
`define MID_CODE_16 16'h8000
`define MID_CODE_14 16'h8000
`define MID_CODE_12 16'h8000
`define RES_16 2'h0
`define RES_14 2'h1
`define RES_12 2'h2
`define FIFO_WIDTH 16
`define FIFO_DEPTH 8
`define FIFO_ABITS 3
`endif

// >>> core/word_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module word_fifo
#(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter ABITS = 3
)
(
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [ABITS-1:0] wr_q;
    reg [ABITS-1:0] rd_q;
    reg [ABITS:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready = (cnt_q != DEPTH[ABITS:0]);
    assign out_valid = (cnt_q != {(ABITS+1){1'b0}});
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q <= {ABITS{1'b0}};
            rd_q <= {ABITS{1'b0}};
            cnt_q <= {(ABITS+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= wr_q + {{(ABITS-1){1'b0}}, 1'b1};
            if (pop)
                rd_q <= rd_q + {{(ABITS-1){1'b0}}, 1'b1};
            if (push && !pop)
                cnt_q <= cnt_q + {{ABITS{1'b0}}, 1'b1};
            else if (pop && !push)
                cnt_q <= cnt_q - {{ABITS{1'b0}}, 1'b1};
        end
    end
endmodule

// >>> core/serial_dac_input_latch.v
// serial write link, dac latch, clear and code decode
`timescale 1ns/1ns
`include "dac_latch_consts.vh"
// How it works
// - with frame select low, data is shifted in msb first on each shift clock rise.
// - after 16 bits, the rise of frame select copies the word into the dac latch.
// - while frame select is high, shift clock edges are ignored.
// - a frame with under 16 clock rises leaves the latch alone and is flagged bad.
// - with over 16 rises, only the last 16 shifted bits reach the latch.
// - the 14-bit variant takes its code left-justified and drops the two low bits.
// - the 12-bit variant takes its code left-justified and drops the four low bits.
// - at reset the unipolar variant loads zero scale.
// - at reset the bipolar variant loads the midscale code of its resolution.
// - a low clear forces the latch to zero or midscale without the shift clock.
// - in unipolar use the code is straight binary and passes through unchanged.
// - in bipolar use the code is offset binary, shown as a signed value.
// - the top four code bits become 15 equal segment selects, the rest stay binary.
module serial_dac_input_latch
#(
    parameter BIPOLAR = 0,
    parameter [1:0] RESOLUTION = `RES_16
)
(
    input wire clk,
    input wire rst,
    input wire frame_sel_n,
    input wire shift_clk,
    input wire serial_data,
    input wire latch_clear_n,
    output reg [15:0] dac_code,
    output reg [15:0] signed_code,
    output reg [14:0] segment_sel,
    output reg [11:0] binary_bits,
    output reg short_frame,
    output reg fifo_full
);
    reg [2:0] fs_sync_q;
    reg [2:0] sc_sync_q;
    reg [2:0] sd_sync_q;
    reg [2:0] cl_sync_q;
    reg fs_q;
    reg fs_d;
    reg sc_q;
    reg sc_d;
    reg sd_q;
    reg sd_d;
    reg cl_q;
    reg cl_d;
    reg [15:0] shift_q;
    reg [15:0] shift_d;
    reg [4:0] cnt_q;
    reg [4:0] cnt_d;
    reg commit_q;
    reg commit_d;
    reg short_d;
    reg [15:0] latch_q;
    reg [15:0] latch_d;
    reg [15:0] dac_code_d;
    reg [15:0] signed_code_d;
    reg [14:0] segment_sel_d;
    reg [11:0] binary_bits_d;
    reg fifo_full_d;
    wire sc_rise;
    wire fs_rise;
    wire fs_fall;
    wire frame_done;
    wire push;
    wire [15:0] commit_word;
    wire fifo_in_ready;
    wire [15:0] fifo_data;
    wire fifo_valid;

    // midscale sits in the top bit for every resolution once left-justified
    localparam [15:0] MID_CODE = (RESOLUTION == `RES_14) ? `MID_CODE_14 :
        (RESOLUTION == `RES_12) ? `MID_CODE_12 : `MID_CODE_16;
    localparam [15:0] RESET_CODE = (BIPOLAR != 0) ? MID_CODE : `ZERO_CODE;

    function [15:0] mask_res;
        input [15:0] w;
        input [1:0] res;
        begin
            case (res)
                `RES_14: mask_res = {w[15:2], 2'h0};
                `RES_12: mask_res = {w[15:4], 4'h0};
                default: mask_res = w;
            endcase
        end
    endfunction

    function [14:0] thermo;
        input [3:0] top;
        integer i;
        begin
            thermo = 15'h0000;
            for (i = 0; i < `SEG_COUNT; i = i + 1)
                thermo[i] = (top > i[3:0]);
        end
    endfunction

    // offset binary as two's complement
    function [15:0] to_signed;
        input [15:0] k;
        begin
            to_signed = {~k[15], k[14:0]};
        end
    endfunction

    // new level only once stages two and three agree
    function settle;
        input [2:0] stages;
        input prev;
        begin
            if (stages[1] == stages[2])
                settle = stages[2];
            else
                settle = prev;
        end
    endfunction

    // strobe for the cycle the settled level turns to lvl
    function turns_to;
        input [2:0] stages;
        input prev;
        input lvl;
        begin
            turns_to = (stages[1] == stages[2]) && (stages[2] == lvl) && (prev != lvl);
        end
    endfunction

    // idle levels at reset, so no false edge follows it
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fs_sync_q <= 3'h7;
            fs_q <= 1'b1;
        end
        else
        begin
            fs_sync_q <= {fs_sync_q[1:0], frame_sel_n};
            fs_q <= fs_d;
        end
    end

    // shift clock and data idle low
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sc_sync_q <= 3'h0;
            sc_q <= 1'b0;
        end
        else
        begin
            sc_sync_q <= {sc_sync_q[1:0], shift_clk};
            sc_q <= sc_d;
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sd_sync_q <= 3'h0;
            sd_q <= 1'b0;
        end
        else
        begin
            sd_sync_q <= {sd_sync_q[1:0], serial_data};
            sd_q <= sd_d;
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cl_sync_q <= 3'h7;
            cl_q <= 1'b1;
        end
        else
        begin
            cl_sync_q <= {cl_sync_q[1:0], latch_clear_n};
            cl_q <= cl_d;
        end
    end

    always @*
    begin
        fs_d = settle(fs_sync_q, fs_q);
        sc_d = settle(sc_sync_q, sc_q);
        sd_d = settle(sd_sync_q, sd_q);
        cl_d = settle(cl_sync_q, cl_q);
    end

    assign sc_rise = turns_to(sc_sync_q, sc_q, 1'b1);
    assign fs_rise = turns_to(fs_sync_q, fs_q, 1'b1);
    assign fs_fall = turns_to(fs_sync_q, fs_q, 1'b0);
    assign frame_done = (cnt_q == `FULL_CNT);
    // commit a cycle late so a shift in the same cycle lands first
    assign push = commit_q && frame_done;
    assign commit_word = mask_res(shift_q, RESOLUTION);

    // data taken at its settled next value, in step with the clock strobe
    always @*
    begin
        shift_d = shift_q;
        cnt_d = cnt_q;
        commit_d = fs_rise;
        short_d = short_frame;
        if (fs_fall)
            cnt_d = 5'h00;
        else if (!fs_q && sc_rise)
        begin
            shift_d = {shift_q[14:0], sd_d};
            // saturates; extra rises keep only the last 16 bits
            if (cnt_q != `FULL_CNT)
                cnt_d = cnt_q + 5'h01;
        end
        if (commit_q)
            short_d = !frame_done;
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            shift_q <= 16'h0000;
            cnt_q <= 5'h00;
            commit_q <= 1'b0;
            short_frame <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            commit_q <= commit_d;
            short_frame <= short_d;
        end
    end

    // buffer between link and latch; a full fifo drops the commit and shows it
    word_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .ABITS(`FIFO_ABITS)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(commit_word),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(cl_q)
    );

    // words wait in the fifo while clear is held
    always @*
    begin
        latch_d = latch_q;
        if (fifo_valid && cl_q)
            latch_d = fifo_data;
    end

    // raw pin clears with no clock; drain waits for the synced clear to go high
    always @(posedge clk or posedge rst or negedge latch_clear_n)
    begin
        if (rst)
            latch_q <= RESET_CODE;
        else if (!latch_clear_n)
            latch_q <= RESET_CODE;
        else
            latch_q <= latch_d;
    end

    // decode a cycle ahead so outputs come straight from flops
    always @*
    begin
        dac_code_d = latch_q;
        signed_code_d = to_signed(latch_q);
        segment_sel_d = thermo(latch_q[15:12]);
        binary_bits_d = latch_q[11:0];
        fifo_full_d = !fifo_in_ready;
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dac_code <= 16'h0000;
            signed_code <= 16'h0000;
            segment_sel <= 15'h0000;
            binary_bits <= 12'h000;
            fifo_full <= 1'b0;
        end
        else
        begin
            dac_code <= dac_code_d;
            signed_code <= signed_code_d;
            segment_sel <= segment_sel_d;
            binary_bits <= binary_bits_d;
            fifo_full <= fifo_full_d;
        end
    end
endmodule

// >>> sim/dac_latch_sva.sv
// port assertions for the serial dac input latch
`timescale 1ns/1ns
module dac_latch_chk
#(
    parameter BIPOLAR = 0
)
(
    input wire clk,
    input wire rst,
    input wire frame_sel_n,
    input wire latch_clear_n,
    input wire [15:0] dac_code,
    input wire [15:0] signed_code,
    input wire [14:0] segment_sel,
    input wire [11:0] binary_bits,
    input wire short_frame
);
    localparam [15:0] home = BIPOLAR ? 16'h8000 : 16'h0000;
    logic [1:0] age_q;
    // outputs settle a cycle or two after reset leaves
    always @(posedge clk or posedge rst)
        if (rst)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence idle8;
        (frame_sel_n && latch_clear_n) [*8];
    endsequence
    AST_SIGNED: assert property (age_q == 2'h3
        |-> signed_code == dac_code - 16'h8000)
        else $error("signed code wrong");
    AST_SEG: assert property (age_q == 2'h3
        |-> segment_sel == (15'h7FFF >> (4'hF - dac_code[15:12])))
        else $error("segments wrong");
    AST_BIN: assert property (age_q == 2'h3 |-> binary_bits == dac_code[11:0])
        else $error("binary bits wrong");
    AST_RST: assert property (age_q == 2'h2 |-> dac_code == home)
        else $error("reset code wrong");
    AST_CLR: assert property (!latch_clear_n [*3] |-> dac_code == home)
        else $error("clear code wrong");
    AST_HOLD: assert property (idle8 ##1 idle8 |=> $stable(dac_code))
        else $error("latch moved while idle");
    AST_UPD: assert property (age_q == 2'h3 && dac_code != $past(dac_code)
        && $past(latch_clear_n) |-> $past(frame_sel_n))
        else $error("latch moved inside a frame");
    AST_IDLE: assert property (frame_sel_n [*8] ##1 frame_sel_n |=> $stable(short_frame))
        else $error("frame flag moved while deselected");
endmodule
bind serial_dac_input_latch dac_latch_chk #(.BIPOLAR(BIPOLAR)) u_chk (.clk(clk), .rst(rst),
    .frame_sel_n(frame_sel_n), .latch_clear_n(latch_clear_n), .dac_code(dac_code),
    .signed_code(signed_code), .segment_sel(segment_sel), .binary_bits(binary_bits),
    .short_frame(short_frame));

// >>> sim/host_spi.sv
// host-side serial writer for the dac latch
`timescale 1ns/1ns
module host_spi
(
    input wire clk,
    output logic frame_sel_n,
    output logic shift_clk,
    output logic serial_data
);
    initial
    begin
        frame_sel_n = 1'b1;
        shift_clk = 1'b0;
        serial_data = 1'b0;
    end
    // half of an 800 ns link period
    task automatic half();
        repeat (4) @(negedge clk);
    endtask
    // n low bits of w, top first; sel low clocks with frame left high
    task automatic send(input logic [31:0] w, input int n, input logic sel);
        frame_sel_n = ~sel;
        half();
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data = w[i];
            half();
            shift_clk = 1'b1;
            half();
            shift_clk = 1'b0;
        end
        half();
        frame_sel_n = 1'b1;
        serial_data = ~serial_data;
        repeat (12) @(negedge clk);
    endtask
endmodule

// >>> sim/serial_dac_input_latch_tb_top.sv
// self-checking bench for the serial dac input latch
`timescale 1ns/1ns
`include "dac_latch_consts.vh"
module serial_dac_input_latch_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic latch_clear_n = 1'b1;
    wire frame_sel_n, shift_clk, serial_data, short_frame, fifo_full;
    wire [15:0] dac_code, signed_code;
    wire [15:0] dac_b14, dac_b12;
    wire [14:0] segment_sel;
    wire [11:0] binary_bits;
    int failures = 0;
    int checks = 0;
    initial
        forever #50 clk = ~clk;
    host_spi u_host (.clk(clk), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
        .serial_data(serial_data));
    serial_dac_input_latch #(.BIPOLAR(0), .RESOLUTION(`RES_16)) u_dut (.clk(clk), .rst(rst),
        .frame_sel_n(frame_sel_n), .shift_clk(shift_clk), .serial_data(serial_data),
        .latch_clear_n(latch_clear_n), .dac_code(dac_code), .signed_code(signed_code),
        .segment_sel(segment_sel), .binary_bits(binary_bits), .short_frame(short_frame),
        .fifo_full(fifo_full));
    serial_dac_input_latch #(.BIPOLAR(1), .RESOLUTION(`RES_14)) u_dut_b14 (
        .clk(clk), .rst(rst),
        .frame_sel_n(frame_sel_n), .shift_clk(shift_clk), .serial_data(serial_data),
        .latch_clear_n(latch_clear_n), .dac_code(dac_b14), .signed_code(), .segment_sel(),
        .binary_bits(), .short_frame(), .fifo_full());
    serial_dac_input_latch #(.BIPOLAR(1), .RESOLUTION(`RES_12)) u_dut_b12 (
        .clk(clk), .rst(rst),
        .frame_sel_n(frame_sel_n), .shift_clk(shift_clk), .serial_data(serial_data),
        .latch_clear_n(latch_clear_n), .dac_code(dac_b12), .signed_code(), .segment_sel(),
        .binary_bits(), .short_frame(), .fifo_full());
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_write();
        u_host.send(32'h0000A5C3, 16, 1'b1);
        chk(dac_code, 16'hA5C3);
        chk(signed_code, 16'h25C3);
        chk({1'b0, segment_sel}, 16'h03FF);
        chk({4'h0, binary_bits}, 16'h05C3);
        chk({15'h0, short_frame}, 16'h0000);
        chk({15'h0, fifo_full}, 16'h0000);
    endtask
    task automatic t_short();
        u_host.send(32'h00001111, 8, 1'b1);
        chk(dac_code, 16'hA5C3);
        chk({15'h0, short_frame}, 16'h0001);
    endtask
    task automatic t_long();
        u_host.send(32'h000F1234, 20, 1'b1);
        chk(dac_code, 16'h1234);
    endtask
    task automatic t_idle();
        u_host.send(32'h0000FFFF, 16, 1'b0);
        chk(dac_code, 16'h1234);
    endtask
    task automatic t_clear();
        latch_clear_n = 1'b0;
        repeat (3) @(negedge clk);
        chk(dac_code, `ZERO_CODE);
        chk(dac_b14, `MID_CODE_14);
        chk(dac_b12, `MID_CODE_12);
        latch_clear_n = 1'b1;
        repeat (4) @(negedge clk);
        u_host.send(32'h00007FFF, 16, 1'b1);
        chk(dac_code, 16'h7FFF);
        chk({1'b0, segment_sel}, 16'h007F);
        chk(dac_b14, 16'h7FFC);
        chk(dac_b12, 16'h7FF0);
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(dac_code, `ZERO_CODE);
        chk(dac_b14, `MID_CODE_14);
        chk(dac_b12, `MID_CODE_12);
        t_write();
        t_short();
        t_long();
        t_idle();
        t_clear();
        finish_test();
    end
endmodule
